// ==== rso_pkg.sv ====
// Constants shared by the clock-setting and oscillator-stop block.
// Assumes a single 10 MHz clock; the second and the least protect delay are converted to cycles here.
package rso_pkg;
  // Clock and time figures
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SECOND_CYC = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned PROTECT_DELAY_MIN_NS = 40000;
  localparam int unsigned PROTECT_DELAY_MAX_NS = 150000;
  localparam int unsigned PROTECT_FAST_MAX_NS = 200000;
  // Least time rounds up to whole cycles
  localparam int unsigned PROTECT_CYC =
    (PROTECT_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PF_CNT_W = 9;

  // Register map
  localparam logic [18:0] ADDR_CLOCK_CONTROL = 19'h7FFF8;
  localparam logic [18:0] ADDR_SECONDS = 19'h7FFF9;
  localparam logic [18:0] ADDR_YEAR = 19'h7FFFF;
  localparam int unsigned NUM_TIME = 7;

  // Field positions
  localparam int unsigned CTRL_SET_BIT = 7;
  localparam int unsigned CTRL_READ_HALT_BIT = 6;
  localparam int unsigned SEC_OSC_HALT_BIT = 7;
  localparam int unsigned DAY_FREQ_TEST_BIT = 6;
  localparam int unsigned IDX_SEC = 0;
  localparam int unsigned IDX_MIN = 1;
  localparam int unsigned IDX_HOUR = 2;
  localparam int unsigned IDX_DAY = 3;
  localparam int unsigned IDX_DATE = 4;
  localparam int unsigned IDX_MONTH = 5;
  localparam int unsigned IDX_YEAR = 6;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic OSC_HALT_RESET = 1'b1;
  localparam logic [55:0] TIME_RESET = 56'h00_01_01_01_00_00_00;

  // BCD limits
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_DAY = 8'h07;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] MIN_ZERO = 8'h00;
  localparam logic [7:0] MIN_ONE = 8'h01;

  // Oscillator state, Gray coded along stop -> start -> run
  typedef enum logic [1:0] {
    OSC_STOPPED = 2'b00,
    OSC_STARTING = 2'b01,
    OSC_RUNNING = 2'b11
  } rso_osc_t;
endpackage : rso_pkg

// ==== rso_tick_div.sv ====
// Restartable cycle divider giving a one-cycle tick every CYC clocks.
// Assumes run and restart come from logic on the same clock.
module rso_tick_div #(
  parameter int unsigned CYC = 10000000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  output logic tick
);
  import rso_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } rso_div_st_t;

  rso_div_st_t st_r;
  rso_div_st_t st_nxt;

  // Count while running; restart puts a full period before the next tick
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart || !run) begin
      st_nxt.cnt = 32'h0;
    end else if (st_r.cnt >= CYC - 1) begin
      st_nxt.cnt = 32'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : rso_tick_div

// ==== rso_clock_set.sv ====
// Clock registers of a battery-backed timekeeping memory: set, halt,
// oscillator stop and power-fail write protection on the memory pins.
// Assumes asynchronous memory pins; all are synchronised before use.
// The static memory array itself lives outside this block.
import rso_pkg::*;

// What this block does
// - Control bit seven freezes visible time updates
// - Clearing set bit loads counters from registers
// - First update one second after set clears
// - Reset clears set and read-halt bits
// - Seconds bit seven halts the oscillator
// - Oscillator halt bit starts out set
// - Oscillator runs one second after release
// - Halt and test bits writable anytime
// - Power fail protects within 40 to 150us
// - Fast fall protection within 200us
// - Read-halt freezes registers, counters keep running
// - Updates complete whole, all registers together
module rso_clock_set #(
  parameter int unsigned SEC_CYC = rso_pkg::SECOND_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [18:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic power_fail,
  output logic write_protect,
  output logic osc_running,
  output logic frequency_test
);
  import rso_pkg::*;

  typedef struct packed {
    logic e1, e2, g1, g2, w1, w2, pf1, pf2;
    logic [18:0] a1, a2;
    logic [7:0] d1, d2;
    logic wr_act;
    logic [18:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] ctrl;
    logic osc_halt_bit;
    logic frequency_test_bit;
    logic [NUM_TIME-1:0][7:0] vis;
    logic [NUM_TIME-1:0][7:0] cnt;
    rso_osc_t osc;
    logic osc_run;
    logic sec_restart;
    logic [PF_CNT_W-1:0] pf_cnt;
    logic wp;
    logic [7:0] dq_out;
    logic dq_oe;
  } rso_st_t;

  rso_st_t st_r;
  rso_st_t st_nxt;
  logic sec_tick;
  logic start_tick;

  // BCD step with wrap; bit 8 is the carry into the next field
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] maxv,
                                         input logic [7:0] minv);
    logic [8:0] r;
    r = '0;
    if (v >= maxv) begin
      r = {1'b1, minv};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v + 8'h01};
    end
    return r;
  endfunction : bcd_inc

  // Last date of the month in BCD, leap years every fourth year
  function automatic logic [7:0] month_end(input logic [7:0] mon,
                                           input logic [7:0] yr);
    logic [7:0] r;
    logic [6:0] ybin;
    ybin = 7'(yr[7:4]) * 7'd10 + 7'(yr[3:0]);
    r = 8'h31;
    if (mon == 8'h02) begin
      r = (ybin[1:0] == 2'b00) ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                 mon == 8'h11) begin
      r = 8'h30;
    end
    return r;
  endfunction : month_end

  // Seconds tick, restarted when a new time is loaded
  rso_tick_div #(.CYC(SEC_CYC)) u_sec_div (
    .clk(clk),
    .rst(rst),
    .run(st_r.osc == OSC_RUNNING),
    .restart(st_r.sec_restart),
    .tick(sec_tick)
  );

  // Start-up delay of the oscillator after its halt bit clears
  rso_tick_div #(.CYC(SEC_CYC)) u_start_div (
    .clk(clk),
    .rst(rst),
    .run(st_r.osc == OSC_STARTING),
    .restart(1'b0),
    .tick(start_tick)
  );

  always_comb begin
    logic wr_now;
    logic commit;
    logic [2:0] idx;
    logic [8:0] step;
    logic carry;
    logic [7:0] rd;
    wr_now = 1'b0;
    commit = 1'b0;
    idx = 3'h0;
    step = '0;
    carry = 1'b0;
    rd = 8'h00;
    st_nxt = st_r;
    st_nxt.sec_restart = 1'b0;

    // Two-stage synchronisers on every pin
    st_nxt.e1 = chip_en_n;
    st_nxt.e2 = st_r.e1;
    st_nxt.g1 = out_en_n;
    st_nxt.g2 = st_r.g1;
    st_nxt.w1 = write_en_n;
    st_nxt.w2 = st_r.w1;
    st_nxt.pf1 = power_fail;
    st_nxt.pf2 = st_r.pf1;
    st_nxt.a1 = addr;
    st_nxt.a2 = st_r.a1;
    st_nxt.d1 = dq_in;
    st_nxt.d2 = st_r.d1;

    // Power fail: protect after the least delay, inside both limits
    if (st_r.pf2) begin
      if (st_r.pf_cnt >= PF_CNT_W'(PROTECT_CYC - 1)) begin
        st_nxt.wp = 1'b1;
      end else begin
        st_nxt.pf_cnt = st_r.pf_cnt + 1'b1;
      end
    end else begin
      st_nxt.pf_cnt = '0;
      st_nxt.wp = 1'b0;
    end

    // Write ends at the earlier rising edge of enable or write strobe
    wr_now = !st_r.e2 && !st_r.w2 && !st_r.wp;
    st_nxt.wr_act = wr_now;
    if (wr_now) begin
      st_nxt.wr_addr = st_r.a2;
      st_nxt.wr_data = st_r.d2;
    end
    commit = st_r.wr_act && !wr_now && !st_r.wp;

    // Oscillator free-runs once started; halt bit stops it at once
    case (st_r.osc)
      OSC_STOPPED: begin
        if (!st_r.osc_halt_bit) begin
          st_nxt.osc = OSC_STARTING;
        end
      end
      OSC_STARTING: begin
        if (st_r.osc_halt_bit) begin
          st_nxt.osc = OSC_STOPPED;
        end else if (start_tick) begin
          st_nxt.osc = OSC_RUNNING;
        end
      end
      OSC_RUNNING: begin
        if (st_r.osc_halt_bit) begin
          st_nxt.osc = OSC_STOPPED;
        end
      end
      default: begin
        st_nxt.osc = OSC_STOPPED;
      end
    endcase
    // Running flag kept in its own flop so the pin is glitch free
    st_nxt.osc_run = (st_nxt.osc == OSC_RUNNING);

    // Counters advance on each second; carries ripple through the date
    if (sec_tick) begin
      carry = 1'b1;
      for (int i = 0; i < NUM_TIME; i++) begin
        if (carry) begin
          case (i)
            IDX_SEC, IDX_MIN:
              step = bcd_inc(st_r.cnt[i], MAX_SEC, MIN_ZERO);
            IDX_HOUR:
              step = bcd_inc(st_r.cnt[i], MAX_HOUR, MIN_ZERO);
            IDX_DAY:
              step = bcd_inc(st_r.cnt[i], MAX_DAY, MIN_ONE);
            IDX_DATE:
              step = bcd_inc(st_r.cnt[i], month_end(st_r.cnt[IDX_MONTH],
                             st_r.cnt[IDX_YEAR]), MIN_ONE);
            IDX_MONTH:
              step = bcd_inc(st_r.cnt[i], MAX_MONTH, MIN_ONE);
            default:
              step = bcd_inc(st_r.cnt[i], MAX_YEAR, MIN_ZERO);
          endcase
          st_nxt.cnt[i] = step[7:0];
          // Day of week wraps on its own, it does not carry into date
          carry = (i == IDX_DAY) ? carry : step[8];
        end
      end
      // All registers copied in one cycle, so a halt never splits it
      if (!st_r.ctrl[CTRL_SET_BIT] && !st_r.ctrl[CTRL_READ_HALT_BIT]) begin
        st_nxt.vis = st_nxt.cnt;
      end
    end

    // Host writes; decode only the clock words at the top of memory
    if (commit) begin
      idx = st_r.wr_addr[2:0];
      if (st_r.wr_addr < ADDR_CLOCK_CONTROL) begin
        idx = 3'h0;
      end else if (idx == 3'h0) begin
        st_nxt.ctrl = st_r.wr_data;
        if (st_r.ctrl[CTRL_SET_BIT] && !st_r.wr_data[CTRL_SET_BIT]) begin
          // Load counters from what the host wrote, restart the second
          st_nxt.cnt = st_r.vis;
          st_nxt.cnt[IDX_SEC][SEC_OSC_HALT_BIT] = 1'b0;
          st_nxt.cnt[IDX_DAY][DAY_FREQ_TEST_BIT] = 1'b0;
          st_nxt.sec_restart = 1'b1;
        end
      end else begin
        // Halt and test bits need no set bit beforehand
        st_nxt.vis[idx - 3'h1] = st_r.wr_data;
        if (idx == 3'(IDX_SEC + 1)) begin
          st_nxt.osc_halt_bit = st_r.wr_data[SEC_OSC_HALT_BIT];
        end
        if (idx == 3'(IDX_DAY + 1)) begin
          st_nxt.frequency_test_bit = st_r.wr_data[DAY_FREQ_TEST_BIT];
        end
      end
    end

    // Read data, halt and test bits shown in their places
    idx = st_r.a2[2:0];
    if (idx == 3'h0) begin
      rd = st_r.ctrl;
    end else if (idx == 3'(IDX_SEC + 1)) begin
      rd = {st_r.osc_halt_bit, st_r.vis[IDX_SEC][6:0]};
    end else if (idx == 3'(IDX_DAY + 1)) begin
      rd = {1'b0, st_r.frequency_test_bit, st_r.vis[IDX_DAY][5:0]};
    end else begin
      rd = st_r.vis[idx - 3'h1];
    end
    st_nxt.dq_out = rd;
    // Deselect in the same cycle that protection starts
    st_nxt.dq_oe = !st_r.e2 && !st_r.g2 && st_r.w2 && !st_nxt.wp &&
                   st_r.a2 >= ADDR_CLOCK_CONTROL;
  end

  // Power-up state: control bits clear, oscillator halted
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.e1 <= 1'b1;
      st_r.e2 <= 1'b1;
      st_r.g1 <= 1'b1;
      st_r.g2 <= 1'b1;
      st_r.w1 <= 1'b1;
      st_r.w2 <= 1'b1;
      st_r.ctrl <= CTRL_RESET;
      st_r.osc_halt_bit <= OSC_HALT_RESET;
      st_r.vis <= TIME_RESET;
      st_r.cnt <= TIME_RESET;
      st_r.osc <= OSC_STOPPED;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dq_out = st_r.dq_out;
  assign dq_oe = st_r.dq_oe;
  assign write_protect = st_r.wp;
  assign osc_running = st_r.osc_run;
  assign frequency_test = st_r.frequency_test_bit;
endmodule : rso_clock_set

// ==== rso_clock_set_chk.sv ====
// Pin-level checker for the clock-setting and oscillator-stop block.
// Assumes pins move just after rising edges of clk.
module rso_clock_set_chk #(
  parameter int unsigned SEC_CYC = 100
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [18:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic power_fail,
  input wire logic write_protect,
  input wire logic osc_running,
  input wire logic frequency_test
);
  timeunit 1ns;
  timeprecision 1ns;
  import rso_pkg::*;
  logic ww;
  logic ww_q;
  logic commit;
  logic ftd;
  logic [18:0] waddr;
  logic [7:0] wdat;
  logic [10:0] pf_cnt;
  logic [31:0] osc_cnt;
  // A write ends when the strobes rise; dropped writes do not count
  assign ww = !chip_en_n && !write_en_n;
  assign commit = ww_q && !ww && !write_protect;
  // Track writes, power-fail time and oscillator start time
  always_ff @(posedge clk) begin
    if (rst) begin
      ww_q <= 1'b0;
      waddr <= 19'h00000;
      wdat <= 8'h00;
      ftd <= 1'b0;
      pf_cnt <= 11'h000;
      osc_cnt <= 32'h0;
    end else begin
      ww_q <= ww;
      if (ww) begin
        waddr <= addr;
        wdat <= dq_in;
      end
      if (commit && waddr == 19'h7FFFC) begin
        ftd <= wdat[DAY_FREQ_TEST_BIT];
      end
      // Saturate so a long outage cannot wrap the count
      if (!power_fail) begin
        pf_cnt <= 11'h000;
      end else if (pf_cnt != 11'h7FF) begin
        pf_cnt <= pf_cnt + 11'h001;
      end
      if (commit && waddr == ADDR_SECONDS && !wdat[7] && !osc_running) begin
        osc_cnt <= 32'h1;
      end else if (osc_running || (commit && waddr == ADDR_SECONDS)) begin
        osc_cnt <= 32'h0;
      end else if (osc_cnt != 32'h0) begin
        osc_cnt <= osc_cnt + 32'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($past(rst) |->
    !osc_running && !frequency_test && !write_protect && !dq_oe)
    else $error("outputs not idle after reset");
  a_osc_halts: assert property (commit && waddr == ADDR_SECONDS && wdat[7]
    |-> ##[1:8] !osc_running)
    else $error("oscillator kept running after halt");
  a_osc_not_early: assert property (osc_running && osc_cnt != 32'h0
    |-> osc_cnt >= SEC_CYC - 8)
    else $error("oscillator started too soon");
  a_osc_not_late: assert property (osc_cnt <= SEC_CYC + 16)
    else $error("oscillator started too late");
  a_test_bit: assert property (commit && waddr == 19'h7FFFC
    |-> ##[1:6] frequency_test == ftd)
    else $error("frequency test bit not taken");
  a_prot_not_early: assert property (pf_cnt != 11'h000 &&
    pf_cnt < 11'h186 && !$past(write_protect) |-> !write_protect)
    else $error("write protect too early");
  a_prot_bound: assert property (pf_cnt == 11'h5C8 |-> write_protect)
    else $error("write protect too late");
  a_prot_release: assert property (!power_fail [*5] |-> !write_protect)
    else $error("write protect held without power fail");
  a_prot_no_read: assert property (write_protect |-> !dq_oe)
    else $error("data driven while deselected");
endmodule : rso_clock_set_chk

bind rso_clock_set rso_clock_set_chk #(.SEC_CYC(SEC_CYC)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
  .write_en_n(write_en_n), .power_fail(power_fail),
  .write_protect(write_protect), .osc_running(osc_running),
  .frequency_test(frequency_test));

// ==== rso_host.sv ====
// Host processor model on the asynchronous memory pins.
// Assumes the block needs each strobe level held several clocks.
module rso_host (
  input wire logic clk,
  output logic [18:0] addr,
  output logic [7:0] dq_in,
  output logic chip_en_n,
  output logic out_en_n,
  output logic write_en_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero
  initial begin
    addr = 19'h00000;
    dq_in = 8'h00;
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    write_en_n = 1'b1;
  end
  // Strobe low four clocks so the synchronisers see a whole write
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    dq_in <= d;
    chip_en_n <= 1'b0;
    write_en_n <= 1'b0;
    repeat (4) @(posedge clk);
    write_en_n <= 1'b1;
    @(posedge clk);
    chip_en_n <= 1'b1;
    dq_in <= ~d; // Released data must not look stale
    repeat (4) @(posedge clk);
  endtask : wr
  // Read data is taken once the three-edge latency has passed
  task automatic rd(input logic [18:0] a, output logic [7:0] d,
                    output logic oe);
    @(posedge clk);
    addr <= a;
    chip_en_n <= 1'b0;
    out_en_n <= 1'b0;
    repeat (5) @(posedge clk);
    d = dq_out;
    oe = dq_oe;
    chip_en_n <= 1'b1;
    out_en_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : rd
endmodule : rso_host

// ==== tb.sv ====
// Self-checking bench for the clock-setting block with a host model.
// Assumes a 100 ns clock and a shortened second of SC cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rso_pkg::*;
  localparam int unsigned SC = 100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_fail = 1'b0;
  logic [18:0] addr;
  logic [7:0] dq_in, dq_out, d;
  logic chip_en_n, out_en_n, write_en_n, dq_oe, oe;
  logic write_protect, osc_running, frequency_test;
  int fail_count = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  rso_host HOST (.clk(clk), .addr(addr), .dq_in(dq_in),
    .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .dq_out(dq_out), .dq_oe(dq_oe));
  rso_clock_set #(.SEC_CYC(SC)) DUT (.clk(clk), .rst(rst), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .chip_en_n(chip_en_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .power_fail(power_fail),
    .write_protect(write_protect), .osc_running(osc_running),
    .frequency_test(frequency_test));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic rdchk(input logic [18:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic en;
    HOST.rd(a, v, en);
    chk1(en, 1'b1);
    chk8(v, exp);
  endtask : rdchk
  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // Power-up state, halted clock and an unmapped read
  task automatic t_reset();
    rdchk(ADDR_CLOCK_CONTROL, 8'h00);
    rdchk(ADDR_SECONDS, 8'h80);
    chk1(osc_running, 1'b0);
    repeat (2 * SC) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h80);
    HOST.rd(19'h00010, d, oe);
    chk1(oe, 1'b0);
  endtask : t_reset
  // Start oscillator and set test bit without the set bit
  task automatic t_osc_start();
    HOST.wr(ADDR_SECONDS, 8'h00);
    chk1(osc_running, 1'b0);
    HOST.wr(19'h7FFFC, 8'h41);
    chk1(frequency_test, 1'b1);
    repeat (SC + 8) @(posedge clk);
    chk1(osc_running, 1'b1);
  endtask : t_osc_start
  // Load a time under the set bit, then release it
  task automatic t_set_clock();
    HOST.wr(ADDR_CLOCK_CONTROL, 8'h80);
    HOST.wr(ADDR_SECONDS, 8'h58);
    HOST.wr(19'h7FFFB, 8'h23);
    HOST.wr(19'h7FFFC, 8'h01);
    chk1(frequency_test, 1'b0);
    repeat (2 * SC) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h58);
    rdchk(19'h7FFFB, 8'h23);
    HOST.wr(ADDR_CLOCK_CONTROL, 8'h00);
    repeat (SC / 2) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h58);
    repeat (SC / 2) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h59);
  endtask : t_set_clock
  // Freeze the visible time while counting goes on
  task automatic t_read_halt();
    HOST.wr(ADDR_CLOCK_CONTROL, 8'h40);
    rdchk(ADDR_CLOCK_CONTROL, 8'h40);
    rdchk(ADDR_SECONDS, 8'h59);
    repeat (2 * SC) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h59);
    HOST.wr(ADDR_CLOCK_CONTROL, 8'h00);
    repeat (SC + 8) @(posedge clk);
    // Three seconds passed, two of them while frozen; minutes carried with them
    rdchk(ADDR_SECONDS, 8'h02);
    rdchk(19'h7FFFA, 8'h01);
  endtask : t_read_halt
  // Halt the oscillator; time must stand still
  task automatic t_osc_stop();
    HOST.wr(ADDR_SECONDS, 8'h80);
    chk1(osc_running, 1'b0);
    rdchk(ADDR_SECONDS, 8'h80);
    repeat (2 * SC) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h80);
  endtask : t_osc_stop
  // Long outage: protect timing, dropped write, recovery
  task automatic t_power_fail();
    power_fail <= 1'b1;
    repeat (390) @(posedge clk);
    chk1(write_protect, 1'b0);
    repeat (20) @(posedge clk);
    chk1(write_protect, 1'b1);
    HOST.wr(ADDR_SECONDS, 8'h00);
    HOST.rd(ADDR_SECONDS, d, oe);
    chk1(oe, 1'b0);
    repeat (1100) @(posedge clk);
    chk1(write_protect, 1'b1);
    power_fail <= 1'b0;
    repeat (8) @(posedge clk);
    chk1(write_protect, 1'b0);
    rdchk(ADDR_SECONDS, 8'h80);
  endtask : t_power_fail
  // Month end at midnight in a common year; stray low write refused
  task automatic t_rollover();
    HOST.wr(19'h00008, 8'h55);
    rdchk(ADDR_CLOCK_CONTROL, 8'h00);
    HOST.wr(ADDR_CLOCK_CONTROL, 8'h80);
    HOST.wr(ADDR_SECONDS, 8'h59);
    HOST.wr(19'h7FFFA, 8'h59);
    HOST.wr(19'h7FFFB, 8'h23);
    HOST.wr(19'h7FFFC, 8'h07);
    HOST.wr(19'h7FFFD, 8'h28);
    HOST.wr(19'h7FFFE, 8'h02);
    HOST.wr(ADDR_YEAR, 8'h01);
    HOST.wr(ADDR_CLOCK_CONTROL, 8'h00);
    // Start-up second plus first tick, read before the second tick
    repeat (SC + 50) @(posedge clk);
    rdchk(ADDR_SECONDS, 8'h00);
    rdchk(19'h7FFFA, 8'h00);
    rdchk(19'h7FFFB, 8'h00);
    rdchk(19'h7FFFC, 8'h01);
    rdchk(19'h7FFFD, 8'h01);
    rdchk(19'h7FFFE, 8'h03);
  endtask : t_rollover
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_osc_start();
    t_set_clock();
    t_read_halt();
    t_osc_stop();
    t_power_fail();
    t_rollover();
    conclude();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : tb
